//--- hdl/ctf_top.sv
// Overview of operation
// - Rate readback fields allow reference-free rate estimate
// - Full-rate flag bit6, divider bits5:2 at 0x5
// - Active oscillator core in bits1:0 at 0x5
// - Oscillator setting low eight bits at 0x4
// - Restart strobe restarts acquisition, keeps mode
// - Detector enable bit2, pattern bits1:0 at 0x3F
// - Mode 3 captures sixteen bits once
// - Clear strobe clears error flag and count
// - Error flag at 0x41, count at 0x40
// - Detector disabled freezes flag and count
// - Generator enable bit2, pattern select bits1:0
// - Generator mode 3 repeats user word
// - Run insertion: value bit5, length eight times field
// - Output clock defaults to half rate
// - Bit2 of 0x1E selects full-rate clock
// - Bit5 of 0x9 routes input around recovery
`timescale 1ns/1ps
module ctf_top #(
	parameter int FIFO_DEPTH = 8,
	parameter int RUN_WIDTH  = 11
) (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       reset,
	// Register port
	input  wire logic       regWrite,
	input  wire logic       regRead,
	input  wire logic [7:0] regAddr,
	input  wire logic [7:0] regWrData,
	output logic      [7:0] regRdData,
	// Oscillator core status
	input  wire logic [9:0] oscillatorSetting,
	input  wire logic       fullRateFlag,
	input  wire logic [3:0] dividerExponent,
	// Line data
	input  wire logic       rxDataBit,
	input  wire logic       rxDataValid,
	input  wire logic       rawInputBit,
	// Outputs
	output logic            txDataBit,
	output logic            txDataValid,
	output logic            outClock,
	output logic            acquisitionRestart,
	output logic            recoveryBypass
);
	////////////////////////////////////////////////////////////////////
	// Registers
	logic [7:0]  acqCtlQ;        // Acquisition control
	logic [7:0]  clkCtlQ;        // Output clock control
	logic [7:0]  genCtlQ;        // Generator control
	logic [7:0]  runLenQ;        // Run length field
	logic [7:0]  detCtlQ;        // Detector control
	logic [31:0] userPatternQ;   // User pattern word
	logic [7:0]  errCountQ;      // Pattern error tally
	logic        errFlagQ;       // Pattern error flag
	logic [15:0] captureQ;       // Sampled data capture
	logic        captureDoneQ;   // One-shot capture taken
	logic [4:0]  captureCntQ;    // Bits captured
	logic [9:0]  oscSetQ;        // Synchronised status
	logic [9:0]  oscSetMetaQ;
	logic [4:0]  rateStatQ;
	logic [4:0]  rateStatMetaQ;
	logic [1:0]  rxMetaQ;
	logic [1:0]  rxQ;
	logic [1:0]  rawMetaQ;
	logic [1:0]  rawQ;
	logic [30:0] detLfsrQ;       // Detector reference
	logic [30:0] genLfsrQ;       // Generator state
	logic [4:0]  userIdxQ;       // User pattern bit index
	logic [RUN_WIDTH-1:0] runCntQ; // Run remaining
	logic        runPhaseQ;      // In inserted run
	logic        clkDivQ;        // Half-rate divider

	////////////////////////////////////////////////////////////////////
	// Decode
	// Write strobes per register
	wire wrAcq    = regWrite && regAddr == ctf_pkg::ACQ_CONTROL_ADDR;
	wire wrDet    = regWrite && regAddr == ctf_pkg::DET_CONTROL_ADDR;
	wire wrPat    = regWrite && regAddr[7:2] == ctf_pkg::USER_PATTERN_ADDR[7:2];
	// Field views of the control registers
	wire detEn    = detCtlQ[ctf_pkg::ENABLE_BIT];
	wire [1:0] detSel = detCtlQ[1:0];
	wire genEn    = genCtlQ[ctf_pkg::ENABLE_BIT];
	wire [1:0] genSel = genCtlQ[1:0];
	wire restartFall = wrAcq && acqCtlQ[ctf_pkg::ACQ_RESTART_BIT]
		&& !regWrData[ctf_pkg::ACQ_RESTART_BIT];
	wire clearFall   = wrDet && detCtlQ[ctf_pkg::DET_CLEAR_BIT]
		&& !regWrData[ctf_pkg::DET_CLEAR_BIT];

	// Feedback taps per polynomial, used by both pattern engines
	function automatic logic lfsrTap(input logic [30:0] s, input logic [1:0] sel);
		case (sel)
			ctf_pkg::SEL_P7:  lfsrTap = s[6] ^ s[5];
			ctf_pkg::SEL_P15: lfsrTap = s[14] ^ s[13];
			default:          lfsrTap = s[30] ^ s[27];
		endcase
	endfunction

	// Newest bit enters at the bottom; the polynomial lives in the taps
	function automatic logic [30:0] lfsrNext(input logic [30:0] s, input logic [1:0] sel,
		input logic b);
		lfsrNext = {s[29:0], b};
	endfunction

	////////////////////////////////////////////////////////////////////
	// Pin synchronisers, two stages before use
	always_ff @(posedge clk_sys) begin
		rxMetaQ       <= {rxDataValid, rxDataBit};
		rxQ           <= rxMetaQ;
		rawMetaQ      <= {1'b0, rawInputBit};
		rawQ          <= rawMetaQ;
		oscSetMetaQ   <= oscillatorSetting;
		oscSetQ       <= oscSetMetaQ;
		rateStatMetaQ <= {fullRateFlag, dividerExponent};
		rateStatQ     <= rateStatMetaQ;
	end
	// Only the second stage feeds logic
	wire rxBit = rxQ[0];
	wire rxVal = rxQ[1];

	////////////////////////////////////////////////////////////////////
	// Control register writes
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			acqCtlQ      <= ctf_pkg::REG_RESET;
			clkCtlQ      <= ctf_pkg::REG_RESET;
			genCtlQ      <= ctf_pkg::REG_RESET;
			runLenQ      <= ctf_pkg::REG_RESET;
			detCtlQ      <= ctf_pkg::REG_RESET;
			userPatternQ <= '0;
		end else if (regWrite) begin
			case (regAddr)
				ctf_pkg::ACQ_CONTROL_ADDR: acqCtlQ <= regWrData;
				ctf_pkg::CLK_CONTROL_ADDR: clkCtlQ <= regWrData;
				ctf_pkg::GEN_CONTROL_ADDR: genCtlQ <= regWrData;
				ctf_pkg::RUN_LENGTH_ADDR:  runLenQ <= regWrData;
				ctf_pkg::DET_CONTROL_ADDR: detCtlQ <= regWrData;
				// Read-only and unmapped offsets fall through and are dropped
				// Pattern bytes sit low byte first from the base offset
				default: begin
					if (wrPat)
						userPatternQ[8*regAddr[1:0] +: 8] <= regWrData;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read mux, registered
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			regRdData <= '0;
		end else if (regRead) begin
			case (regAddr)
				ctf_pkg::OSC_SETTING_LOW_ADDR: regRdData <= oscSetQ[7:0];
				ctf_pkg::RATE_READBACK_ADDR: regRdData <= {1'b0, rateStatQ, oscSetQ[9:8]};
				// Control registers read back as written
				ctf_pkg::ACQ_CONTROL_ADDR:   regRdData <= acqCtlQ;
				ctf_pkg::CLK_CONTROL_ADDR:   regRdData <= clkCtlQ;
				ctf_pkg::GEN_CONTROL_ADDR:   regRdData <= genCtlQ;
				ctf_pkg::RUN_LENGTH_ADDR:    regRdData <= runLenQ;
				ctf_pkg::DET_CONTROL_ADDR:   regRdData <= detCtlQ;
				ctf_pkg::ERR_COUNT_ADDR:     regRdData <= errCountQ;
				ctf_pkg::ERR_FLAG_ADDR:      regRdData <= {7'h00, errFlagQ};
				// Capture halves, low byte first
				ctf_pkg::CAPTURE_LOW_ADDR:   regRdData <= captureQ[7:0];
				ctf_pkg::CAPTURE_HIGH_ADDR:  regRdData <= captureQ[15:8];
				default: regRdData <= wrPat ? 8'h00
					: (regAddr[7:2] == ctf_pkg::USER_PATTERN_ADDR[7:2])
					? userPatternQ[8*regAddr[1:0] +: 8] : 8'h00;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Acquisition restart pulse and bypass select
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			acquisitionRestart <= 1'b0;
			recoveryBypass     <= 1'b0;
		end else begin
			acquisitionRestart <= restartFall;
			// Bypass route
			// Follows the stored bit, so it lags the write by two cycles
			recoveryBypass     <= acqCtlQ[ctf_pkg::BYPASS_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Pattern detector: self-seeding from received bits
	// Checking and capture share the received stream
	// Checking runs only for the three sequence codes, never in capture mode
	wire detRun       = detEn && rxVal && detSel != ctf_pkg::SEL_USER;
	// Capture mode armed; leaving it rearms the one-shot
	wire capArmed     = detEn && detSel == ctf_pkg::SEL_USER;
	// Received bit against the prediction from earlier received bits
	wire detBitErr    = rxBit ^ lfsrTap(detLfsrQ, detSel);
	// Tally stops at full scale instead of wrapping back to zero
	wire errCountFull = errCountQ == 8'hFF;

	// Reference history; it shifts on a clear too, so a clear never
	// knocks the prediction out of step with the line
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			detLfsrQ <= '0;
		end else if (detRun) begin
			detLfsrQ <= lfsrNext(detLfsrQ, detSel, rxBit);
		end
	end

	// Error flag and tally; a clear wins over an error in the same cycle
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			errCountQ <= '0;
			errFlagQ  <= 1'b0;
		end else if (clearFall) begin
			errCountQ <= '0;
			errFlagQ  <= 1'b0;
		end else if (detRun && detBitErr) begin
			// Flag is sticky until the next clear
			errFlagQ <= 1'b1;
			if (!errCountFull)
				errCountQ <= errCountQ + 8'h01;
		end
	end

	// One-shot capture of sixteen received bits
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			captureQ     <= '0;
			captureDoneQ <= 1'b0;
			captureCntQ  <= '0;
		// Rearm whenever capture mode is left
		end else if (!capArmed) begin
			captureDoneQ <= 1'b0;
			captureCntQ  <= '0;
		end else if (rxVal && !captureDoneQ) begin
			// Newest bit lands in bit 0; held once sixteen are in
			captureQ     <= {captureQ[14:0], rxBit};
			captureCntQ  <= captureCntQ + 5'h01;
			captureDoneQ <= captureCntQ == 5'(ctf_pkg::CAPTURE_LEN - 1);
		end
	end

	////////////////////////////////////////////////////////////////////
	// Generator, feeding the FIFO
	logic genBitW;
	logic fifoReadyW;
	wire  runLenZero = runLenQ == 8'h00;
	wire  [RUN_WIDTH-1:0] runTotal = RUN_WIDTH'(runLenQ) * RUN_WIDTH'(ctf_pkg::RUN_SCALE);
	wire  genStep = genEn && fifoReadyW;
	wire  prbsBit = lfsrTap(genLfsrQ, genSel);
	assign genBitW = runPhaseQ ? genCtlQ[ctf_pkg::RUN_VALUE_BIT]
		: (genSel == ctf_pkg::SEL_USER) ? userPatternQ[userIdxQ] : prbsBit;

	// Nothing advances while the FIFO refuses a bit
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			genLfsrQ  <= '1;
			// Bit 31 first: the user word goes out MSB first
			userIdxQ  <= '1;
			runCntQ   <= '0;
			runPhaseQ <= 1'b0;
		end else if (genStep) begin
			// Insert a run after each pattern word
			if (runPhaseQ) begin
				runCntQ   <= runCntQ - 1'b1;
				runPhaseQ <= runCntQ != RUN_WIDTH'(1);
			end else begin
				genLfsrQ <= lfsrNext(genLfsrQ, genSel, prbsBit);
				userIdxQ <= userIdxQ - 1'b1;
				// Word end starts a run; a zero field inserts none
				if (userIdxQ == 5'h00 && genCtlQ[ctf_pkg::RUN_INSERT_BIT] && !runLenZero) begin
					runPhaseQ <= 1'b1;
					runCntQ   <= runTotal;
				end
			end
		end
	end

	// Eight bits of slack let the generator run ahead of the drain
	logic fifoValidW;
	logic fifoBitW;
	ctf_fifo #(
		.WIDTH (1),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_sys  (clk_sys),
		.reset    (reset),
		.inValid  (genEn),
		.inReady  (fifoReadyW),
		.inData   (genBitW),
		.outValid (fifoValidW),
		.outReady (clkDivQ),
		.outData  (fifoBitW)
	);

	////////////////////////////////////////////////////////////////////
	// Output data and clock
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			txDataBit   <= 1'b0;
			txDataValid <= 1'b0;
			outClock    <= 1'b0;
			clkDivQ     <= 1'b0;
		end else begin
			// Divider high phase is the drain slot of the FIFO
			clkDivQ <= ~clkDivQ;
			// Half rate unless selected full
			// Full rate holds the clock high: each valid cycle is one bit
			outClock <= clkCtlQ[ctf_pkg::FULL_CLK_BIT] ? 1'b1 : clkDivQ;
			// Bypass wins over generator and recovered data
			if (acqCtlQ[ctf_pkg::BYPASS_BIT]) begin
				txDataBit   <= rawQ[0];
				txDataValid <= 1'b1;
			// Generator bits leave at the divided rate
			end else if (genEn) begin
				txDataBit   <= fifoBitW;
				txDataValid <= fifoValidW && clkDivQ;
			// Otherwise recovered data passes straight through
			end else begin
				txDataBit   <= rxBit;
				txDataValid <= rxVal;
			end
		end
	end
endmodule

//--- hdl/ctf_pkg.sv
package ctf_pkg;
	// Register offsets
	localparam logic [7:0] OSC_SETTING_LOW_ADDR = 8'h04;
	localparam logic [7:0] RATE_READBACK_ADDR   = 8'h05;
	localparam logic [7:0] ACQ_CONTROL_ADDR     = 8'h09;
	localparam logic [7:0] CLK_CONTROL_ADDR     = 8'h1E;
	localparam logic [7:0] GEN_CONTROL_ADDR     = 8'h39;
	localparam logic [7:0] RUN_LENGTH_ADDR      = 8'h3A;
	localparam logic [7:0] DET_CONTROL_ADDR     = 8'h3F;
	localparam logic [7:0] ERR_COUNT_ADDR       = 8'h40;
	localparam logic [7:0] ERR_FLAG_ADDR        = 8'h41;
	localparam logic [7:0] CAPTURE_LOW_ADDR     = 8'h42;
	localparam logic [7:0] CAPTURE_HIGH_ADDR    = 8'h43;
	localparam logic [7:0] USER_PATTERN_ADDR    = 8'h44;
	// Field positions
	localparam int ACQ_RESTART_BIT = 6;
	localparam int BYPASS_BIT      = 5;
	localparam int FULL_CLK_BIT    = 2;
	localparam int ENABLE_BIT      = 2;
	localparam int DET_CLEAR_BIT   = 3;
	localparam int RUN_INSERT_BIT  = 4;
	localparam int RUN_VALUE_BIT   = 5;
	localparam int FULL_RATE_POS   = 6;
	localparam int DIV_EXP_LSB     = 2;
	// Pattern select codes
	localparam logic [1:0] SEL_P7   = 2'h0;
	localparam logic [1:0] SEL_P15  = 2'h1;
	localparam logic [1:0] SEL_P31  = 2'h2;
	localparam logic [1:0] SEL_USER = 2'h3;
	// Misc
	localparam logic [7:0] REG_RESET   = 8'h00;
	localparam int         RUN_SCALE   = 8;
	localparam int         CAPTURE_LEN = 16;
endpackage

//--- hdl/ctf_fifo.sv
`timescale 1ns/1ps
module ctf_fifo #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             reset,
	// Fill side
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	// Drain side
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] memQ [DEPTH];   // Storage
	logic [AW-1:0]    wrPtrQ;         // Write index
	logic [AW-1:0]    rdPtrQ;         // Read index
	logic [AW:0]      countQ;         // Fill level
	logic             pushW;
	logic             popW;

	assign pushW = inValid & inReady;
	assign popW  = outValid & outReady;

	////////////////////////////////////////////////////////////////////
	// Pointers and level; full refuses, empty withholds
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			wrPtrQ   <= '0;
			rdPtrQ   <= '0;
			countQ   <= '0;
			inReady  <= 1'b1;
			outValid <= 1'b0;
		end else begin
			if (pushW)
				wrPtrQ <= (wrPtrQ == AW'(DEPTH-1)) ? '0 : wrPtrQ + 1'b1;
			if (popW)
				rdPtrQ <= (rdPtrQ == AW'(DEPTH-1)) ? '0 : rdPtrQ + 1'b1;
			countQ   <= countQ + (AW+1)'(pushW) - (AW+1)'(popW);
			inReady  <= (countQ + (AW+1)'(pushW) - (AW+1)'(popW)) != (AW+1)'(DEPTH);
			outValid <= (countQ + (AW+1)'(pushW) - (AW+1)'(popW)) != '0;
		end
	end

	// Storage write
	always_ff @(posedge clk_sys) begin
		if (pushW)
			memQ[wrPtrQ] <= inData;
	end

	// Registered read data, pre-fetched at the next head
	always_ff @(posedge clk_sys) begin
		if (reset)
			outData <= '0;
		else if (popW)
			outData <= (pushW && countQ == (AW+1)'(1)) ? inData
				: memQ[(rdPtrQ == AW'(DEPTH-1)) ? '0 : rdPtrQ + 1'b1];
		else if (pushW && countQ == '0)
			outData <= inData;
	end
endmodule

//--- tb/ctf_line_src.sv
`timescale 1ns/1ps
module ctf_line_src (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       reset,
	// Pattern select and fault injection
	input  wire logic [1:0] srcMode,
	input  wire logic       inject,
	// Recovered line data
	output logic            rxDataBit,
	output logic            rxDataValid
);
	logic [30:0] hist_q;  // Past clean bits, newest in bit 0
	logic        nextBit; // Next clean bit
	// Taps for orders seven, fifteen and thirty-one
	assign nextBit = (srcMode == 2'h0) ? hist_q[5] ^ hist_q[6]
		: (srcMode == 2'h1) ? hist_q[13] ^ hist_q[14] : hist_q[27] ^ hist_q[30];
	// Flipped bit is not fed back, so one fault stays one fault
	always_ff @(posedge clk_sys) begin
		hist_q      <= reset ? 31'h7FFFFFFF : {hist_q[29:0], nextBit};
		rxDataBit   <= nextBit ^ inject;
		rxDataValid <= !reset;
	end
endmodule

//--- tb/ctf_top_props.sv
`timescale 1ns/1ps
module ctf_top_props (
	// Clock and reset
	input wire logic       clk_sys,
	input wire logic       reset,
	// Register port
	input wire logic       regWrite,
	input wire logic       regRead,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic [7:0] regRdData,
	// Control outputs
	input wire logic       outClock,
	input wire logic       acquisitionRestart,
	input wire logic       recoveryBypass
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);
	////////////////////////////////////////////////////////////////
	logic wrAcq;     // Write to acquisition control
	logic wrHi;      // Restart bit written high
	logic wrLo;      // Restart bit written low
	logic wrClk;     // Write to output clock control
	logic fullClk_q; // Shadow of the full-rate select
	assign wrAcq = regWrite && regAddr == ctf_pkg::ACQ_CONTROL_ADDR;
	assign wrHi  = wrAcq && regWrData[6];
	assign wrLo  = wrAcq && !regWrData[6];
	assign wrClk = regWrite && regAddr == ctf_pkg::CLK_CONTROL_ADDR;
	// Shadow kept here so clock checks need no design internals
	always_ff @(posedge clk_sys) begin
		fullClk_q <= reset ? 1'b0 : (wrClk ? regWrData[2] : fullClk_q);
	end
	////////////////////////////////////////////////////////////////
	sequence s_strobe;
		wrHi ##1 wrLo;
	endsequence
	// Four settled cycles cover the register and output flop
	sequence s_half;
		(!fullClk_q && !reset) [*4];
	endsequence
	sequence s_full;
		(fullClk_q && !reset) [*4];
	endsequence
	AST_RESTART_AFTER: assert property (s_strobe |=> acquisitionRestart)
		else $error("restart missing after strobe pair");
	AST_RESTART_CAUSE: assert property (acquisitionRestart |-> $past(wrLo) && $past(wrHi, 2))
		else $error("restart without strobe pair");
	AST_RESTART_SHORT: assert property (acquisitionRestart |=> !acquisitionRestart)
		else $error("restart pulse too long");
	// Bypass output follows the stored bit, two edges after the write
	AST_BYPASS_ON: assert property (wrAcq && regWrData[5] |-> ##2 recoveryBypass)
		else $error("bypass not entered");
	AST_BYPASS_OFF: assert property (wrAcq && !regWrData[5] |-> ##2 !recoveryBypass)
		else $error("bypass not left");
	AST_BYPASS_HOLD: assert property (!wrAcq ##1 !wrAcq |=> $stable(recoveryBypass))
		else $error("bypass changed without write");
	AST_CLK_HALF: assert property (s_half |-> outClock != $past(outClock))
		else $error("output clock not toggling");
	AST_CLK_FULL: assert property (s_full |-> outClock)
		else $error("output clock not held");
	AST_RD_UNMAPPED: assert property (regRead && regAddr >= 8'h50 |=> regRdData == 8'h00)
		else $error("unmapped read not zero");
	AST_RD_HOLD: assert property (!regRead |=> $stable(regRdData))
		else $error("read data moved without read");
endmodule
bind ctf_top ctf_top_props i_ctf_top_props (.*);

//--- tb/ctf_top_tb.sv
`timescale 1ns/1ps
module ctf_top_tb;
	// Design and partner nets
	logic       clk_sys, reset, regWrite, regRead, fullRateFlag, rawInputBit, inject;
	logic [7:0] regAddr, regWrData, regRdData, rdv, cnt;
	logic [9:0] oscillatorSetting;
	logic [3:0] dividerExponent;
	logic [1:0] srcMode;
	logic       rxDataBit, rxDataValid, txDataBit, txDataValid, outClock;
	logic       acquisitionRestart, recoveryBypass;
	logic       bits[$];                 // Generator bits seen
	int         tapA[3] = '{6, 14, 28};  // Short tap per order
	int         tapB[3] = '{7, 15, 31};  // Long tap per order
	int         n_fail = 0;
	int         checked = 0;
	int         cycles = 0;
	int         pulses = 0;              // Restart pulses seen
	ctf_top i_ctf_top (
		.clk_sys(clk_sys), .reset(reset), .regWrite(regWrite), .regRead(regRead),
		.regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
		.oscillatorSetting(oscillatorSetting), .fullRateFlag(fullRateFlag),
		.dividerExponent(dividerExponent), .rxDataBit(rxDataBit), .rxDataValid(rxDataValid),
		.rawInputBit(rawInputBit), .txDataBit(txDataBit), .txDataValid(txDataValid),
		.outClock(outClock), .acquisitionRestart(acquisitionRestart),
		.recoveryBypass(recoveryBypass)
	);
	ctf_line_src i_ctf_line_src (
		.clk_sys(clk_sys), .reset(reset), .srcMode(srcMode), .inject(inject),
		.rxDataBit(rxDataBit), .rxDataValid(rxDataValid)
	);
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	// Hang guard and pulse tally
	always @(posedge clk_sys) begin
		cycles++;
		pulses += int'(acquisitionRestart === 1'b1);
		if (cycles == 20000) begin
			n_fail++;
			end_of_test;
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic end_of_test;
		if (n_fail == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	// One register cycle: op bit0 writes, bit1 reads; strobes stay up for chaining
	task automatic bus(input logic [1:0] op, input logic [7:0] a, input logic [7:0] d);
		regWrite = op[0];
		regRead = op[1];
		regAddr = a;
		regWrData = d;
		step(1);
		rdv = regRdData;
	endtask
	// Flip one line bit, then let it pass the taps
	task automatic fault;
		inject = 1'b1;
		step(1);
		inject = 1'b0;
		step(40);
	endtask
	task automatic collect(input int n);
		bits = {};
		while (bits.size() < n) begin
			step(1);
			if (txDataValid === 1'b1)
				bits.push_back(txDataBit);
		end
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_rate;
		oscillatorSetting = 10'h2BA;
		fullRateFlag = 1'b1;
		dividerExponent = 4'h9;
		step(8);
		bus(2'h1, 8'h05, 8'hFF);
		bus(2'h2, 8'h04, 8'h00);
		check(rdv, 8'hBA);
		bus(2'h2, 8'h05, 8'h00);
		check(rdv, 8'h66);
		bus(2'h2, 8'h50, 8'h00);
		check(rdv, 8'h00);
	endtask
	task automatic t_ctrl;
		int p0;
		logic oc;
		p0 = pulses;
		// Bypass set while the restart bit is written high then low
		bus(2'h1, 8'h09, 8'h20);
		bus(2'h1, 8'h09, 8'h60);
		bus(2'h1, 8'h09, 8'h20);
		bus(2'h0, 8'h00, 8'h00);
		step(4);
		check(pulses - p0, 1);
		check(recoveryBypass, 1'b1);
		rawInputBit = 1'b1;
		step(8);
		check(txDataBit, 1'b1);
		rawInputBit = 1'b0;
		step(8);
		check(txDataBit, 1'b0);
		bus(2'h1, 8'h09, 8'h00);
		bus(2'h0, 8'h00, 8'h00);
		oc = outClock;
		step(1);
		check(outClock ^ oc, 1'b1);
		// Full rate chosen by bit2 of 0x1E holds the clock high
		bus(2'h1, 8'h1E, 8'h04);
		bus(2'h0, 8'h00, 8'h00);
		step(3);
		check(outClock, 1'b1);
		bus(2'h1, 8'h1E, 8'h00);
	endtask
	task automatic t_det;
		for (int m = 0; m < 3; m++) begin
			srcMode = 2'(m);
			bus(2'h1, 8'h3F, 8'h04 | 8'(m));
			step(100);
			bus(2'h1, 8'h3F, 8'h0C | 8'(m));
			bus(2'h1, 8'h3F, 8'h04 | 8'(m));
			bus(2'h2, 8'h41, 8'h00);
			check(rdv[0], 1'b0);
			fault;
			bus(2'h2, 8'h41, 8'h00);
			check(rdv[0], 1'b1);
			bus(2'h2, 8'h40, 8'h00);
			check(rdv != 8'h00, 1'b1);
		end
		cnt = rdv;
		bus(2'h1, 8'h3F, 8'h02);
		fault;
		bus(2'h2, 8'h40, 8'h00);
		check(rdv, cnt);
		bus(2'h1, 8'h3F, 8'h08);
		bus(2'h1, 8'h3F, 8'h00);
		bus(2'h2, 8'h41, 8'h00);
		check(rdv[0], 1'b0);
		bus(2'h2, 8'h40, 8'h00);
		check(rdv, 8'h00);
		bus(2'h1, 8'h3F, 8'h07);
		fault;
		bus(2'h2, 8'h40, 8'h00);
		check(rdv, 8'h00);
		bus(2'h2, 8'h42, 8'h00);
		cnt = rdv;
		bus(2'h2, 8'h43, 8'h00);
		check({rdv, cnt} != 16'h0000, 1'b1);
	endtask
	task automatic t_gen;
		int bad;
		int run;
		for (int m = 0; m < 4; m++) begin
			bus(2'h1, 8'h44 + 8'(m), 8'hAA);
			bus(2'h1, 8'h39, 8'h04 | 8'(m));
			collect(160);
			bad = 0;
			for (int n = 48; n < 160; n++)
				bad += int'(m < 3 ? bits[n] !== (bits[n - tapA[m]] ^ bits[n - tapB[m]])
					: bits[n] === bits[n - 1]);
			check(bad, 0);
		end
		bus(2'h1, 8'h3A, 8'h01);
		bus(2'h1, 8'h39, 8'h37);
		collect(200);
		run = 0;
		bad = 0;
		for (int n = 16; n < 200; n++) begin
			run = (bits[n] === 1'b1) ? run + 1 : 0;
			bad = (run > bad) ? run : bad;
		end
		check(bad, 9);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		{regWrite, regRead, inject, rawInputBit, fullRateFlag} = 5'h00;
		{regAddr, regWrData, oscillatorSetting, dividerExponent} = 30'h0;
		srcMode = 2'h0;
		reset = 1'b1;
		step(2);
		reset = 1'b0;
		t_rate;
		t_ctrl;
		t_det;
		t_gen;
		end_of_test;
	end
endmodule
